// file: hdl/qhp_host_port.sv
module qhp_host_port #(
  parameter int NCH = qhp_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_style_select,
  input wire logic reset_pin,
  input wire logic prescaler_strap,
  input wire logic chip_select_a,
  input wire logic chip_select_b,
  input wire logic chip_select_c,
  input wire logic chip_select_d,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [qhp_pkg::ADDR_W-1:0] addr,
  input wire logic [qhp_pkg::DATA_W-1:0] data_in,
  output logic [qhp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [NCH-1:0] serial_rx,
  input wire logic [NCH-1:0] ring_indicator,
  input wire logic third_channel_clock_in,
  output logic [NCH-1:0] serial_tx,
  output logic [NCH-1:0] ring_status,
  output logic [NCH-1:0] chan_reset,
  output logic [NCH-1:0] prescale_div4,
  output logic chc_clock_level
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int SW = 9 + qhp_pkg::ADDR_W;
  logic [SW-1:0] sy1_r, sy2_r;
  logic [qhp_pkg::DATA_W-1:0] dsy1_r, dsy2_r;
  logic [NCH-1:0] rx1_r, rx2_r, ri1_r, ri2_r;
  logic chc1_r, chc2_r;
  // chip select pins double as cs/addr lines in read/write style
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sy1_r <= '1;
      sy2_r <= '1;
    end else begin
      sy1_r <= {bus_style_select, reset_pin, prescaler_strap, chip_select_a, chip_select_b,
                chip_select_c, chip_select_d, read_strobe_n, write_strobe_n, addr};
      sy2_r <= sy1_r;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dsy1_r <= '0;
      dsy2_r <= '0;
      rx1_r <= '1;
      rx2_r <= '1;
      ri1_r <= '1;
      ri2_r <= '1;
      chc1_r <= 1'b0;
      chc2_r <= 1'b0;
    end else begin
      dsy1_r <= data_in; // full byte lane
      dsy2_r <= dsy1_r;
      rx1_r <= serial_rx;
      rx2_r <= rx1_r;
      ri1_r <= ring_indicator;
      ri2_r <= ri1_r;
      chc1_r <= third_channel_clock_in;
      chc2_r <= chc1_r;
    end
  end

  logic style_s, rpin_s, strap_s, csa_s, csb_s, csc_s, csd_s, rd_s, wr_s;
  logic [qhp_pkg::ADDR_W-1:0] addr_s;
  assign {style_s, rpin_s, strap_s, csa_s, csb_s, csc_s, csd_s, rd_s, wr_s, addr_s} = sy2_r;

  // ****************************************
  // reset pulse qualification
  // ****************************************
  // polarity follows bus style; pulse must last the minimum before acting
  logic rst_req;
  logic [3:0] rcnt_r;
  logic dev_rst_r;
  assign rst_req = style_s ? rpin_s : !rpin_s;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcnt_r <= '0;
      dev_rst_r <= 1'b1;
    end else if (rst_req) begin
      if (rcnt_r < 4'(qhp_pkg::RESET_MIN_CYC)) begin
        rcnt_r <= rcnt_r + 4'h1;
      end
      if (rcnt_r + 4'h1 >= 4'(qhp_pkg::RESET_MIN_CYC)) begin
        dev_rst_r <= 1'b1;
      end
    end else begin
      rcnt_r <= '0;
      dev_rst_r <= 1'b0; // release already synchronised
    end
  end

  // ****************************************
  // channel decode
  // ****************************************
  // select mask, one-hot in read/write style, any mix of channels in strobe style; style pin picks the decode
  function automatic logic [NCH-1:0] ch_mask(input logic style, input logic a,
                                             input logic b, input logic c, input logic d);
    logic [NCH-1:0] m;
    m = '0;
    if (style) begin
      m = {!d, !c, !b, !a};
    end else if (!a) begin
      m[{c, b}] = 1'b1; // hi=c pin, lo=b pin
    end
    return m;
  endfunction : ch_mask

  logic [NCH-1:0] sel;
  logic one_sel, rd_act, wr_act;
  logic [1:0] sel_idx;
  assign sel = ch_mask(style_s, csa_s, csb_s, csc_s, csd_s);
  assign one_sel = (sel != '0) && ((sel & (sel - 1'b1)) == '0);
  // read/write style: data cycle while select low, rd_not_wr on write strobe pin
  assign rd_act = style_s ? !rd_s : (!csa_s && wr_s);
  assign wr_act = style_s ? !wr_s : (!csa_s && !wr_s);
  always_comb begin
    sel_idx = qhp_pkg::CH_A;
    for (int i = 0; i < NCH; i++) begin
      if (sel[i]) begin
        sel_idx = 2'(i);
      end
    end
  end

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  // cycle sampled on clk through the synchronisers, begun and ended by select and strobe
  qhp_pkg::qhp_state_t st_r;
  logic [NCH-1:0] wsel_r;
  logic [qhp_pkg::DATA_W-1:0] wdat_r;
  logic [qhp_pkg::ADDR_W-1:0] waddr_r;
  logic wr_commit;
  assign wr_commit = (st_r == qhp_pkg::ST_WRITE) && !wr_act; // strobe rise, or select rise in read/write style
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst_r) begin
      st_r <= qhp_pkg::ST_IDLE;
      wsel_r <= '0;
      wdat_r <= '0;
      waddr_r <= '0;
    end else begin
      case (st_r)
        qhp_pkg::ST_IDLE: begin
          if (rd_act && sel != '0) begin
            st_r <= qhp_pkg::ST_READ;
          end else if (wr_act && sel != '0) begin
            st_r <= qhp_pkg::ST_WRITE;
          end
        end
        qhp_pkg::ST_READ: begin
          if (!rd_act) begin
            st_r <= qhp_pkg::ST_IDLE;
          end
        end
        qhp_pkg::ST_WRITE: begin
          // hold last data seen while strobe low
          wsel_r <= sel;
          wdat_r <= dsy2_r;
          waddr_r <= addr_s;
          if (!wr_act) begin
            st_r <= qhp_pkg::ST_IDLE;
          end
        end
        default: st_r <= qhp_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // register store and prescaler
  // ****************************************
  logic [NCH-1:0] wen;
  logic [qhp_pkg::DATA_W-1:0] rdata;
  // all selects low broadcasts the write in strobe style; read/write style writes one channel
  assign wen = wr_commit ? wsel_r : '0;
  qhp_regmem u_mem (
    .clk(clk),
    .rst_n(rst_n && !dev_rst_r),
    .wr_en(wen),
    .addr(wr_commit ? waddr_r : addr_s),
    .wdata(wdat_r),
    .rd_ch(sel_idx),
    .rdata(rdata)
  );

  // strap caught while reset held, then bit 7 writes take over
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale_div4 <= '0;
    end else if (dev_rst_r) begin
      prescale_div4 <= {NCH{!strap_s}};
    end else if (waddr_r == qhp_pkg::MCR_ADDR) begin
      for (int i = 0; i < NCH; i++) begin
        if (wen[i]) begin
          prescale_div4[i] <= wdat_r[qhp_pkg::PRESC_BIT];
        end
      end
    end
  end

  // ****************************************
  // data bus and serial outputs
  // ****************************************
  // multi-select reads never drive, avoiding contention
  assign data_oe = (st_r == qhp_pkg::ST_READ) && rd_act && one_sel;
  always_ff @(posedge clk) begin
    if (!rst_n || dev_rst_r) begin
      data_out <= qhp_pkg::REG_RESET;
      serial_tx <= '1;
      ring_status <= '1;
      chc_clock_level <= 1'b0;
    end else begin
      data_out <= rdata;
      serial_tx <= rx2_r | ~ri2_r | ri2_r; // idle high; rx not looped
      ring_status <= ri2_r; // status only
      chc_clock_level <= chc2_r;
    end
  end
  assign chan_reset = {NCH{dev_rst_r}};

  // ****************************************
  // checks
  // ****************************************
  a_tx_reset_high: assert property (@(posedge clk) disable iff (!rst_n)
    $past(dev_rst_r) |-> serial_tx == '1) else $error("tx not high in reset");
  a_oe_single_sel: assert property (@(posedge clk) disable iff (!rst_n)
    data_oe |-> one_sel && rd_act) else $error("bus driven without single read");
  // the minimum pulse is one synchronised sample at this clock rate
  a_reset_hold_min: assert property (@(posedge clk) disable iff (!rst_n)
    !dev_rst_r ##1 dev_rst_r |->
      $past(rst_req) && ($past(rcnt_r) + 4'h1 >= 4'(qhp_pkg::RESET_MIN_CYC)))
    else $error("reset acted on short pulse");
  a_reset_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    (!style_s && !rpin_s) |=> dev_rst_r) else $error("low reset ignored in rw style");
  a_reset_strobe_hi: assert property (@(posedge clk) disable iff (!rst_n)
    (style_s && rpin_s) |=> dev_rst_r) else $error("high reset ignored in strobe style");
  a_strap_sample: assert property (@(posedge clk) disable iff (!rst_n)
    dev_rst_r ##1 dev_rst_r |-> prescale_div4 == {NCH{!$past(strap_s)}})
    else $error("strap not sampled");
  a_sel_decode: assert property (@(posedge clk) disable iff (!rst_n)
    (!style_s && csa_s) |-> sel == '0) else $error("select without cs");
  // the channels written must be those selected while the strobe was low
  a_write_commit: assert property (@(posedge clk) disable iff (!rst_n || dev_rst_r)
    (st_r == qhp_pkg::ST_WRITE && wr_act) ##1 !wr_act |-> wen == $past(sel))
    else $error("write not committed");
  a_no_oe_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_act |-> !data_oe) else $error("drive outside read");
endmodule : qhp_host_port

// file: hdl/qhp_pkg.sv
package qhp_pkg;
  // channel decode
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int REGS_PER_CH = 8;
  // prescaler control bit in the modem control register
  localparam int PRESC_BIT = 7;
  localparam logic [2:0] MCR_ADDR = 3'h4;
  localparam logic [DATA_W-1:0] MCR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // prescale divide values
  localparam logic [2:0] PRESC_DIV1 = 3'h1;
  localparam logic [2:0] PRESC_DIV4 = 3'h4;
  // reset pulse minimum, 20 MHz clock
  localparam int RESET_MIN_NS = 40;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // channel codes in read/write style
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_D = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } qhp_state_t;
endpackage : qhp_pkg

// file: hdl/qhp_regmem.sv
// per-channel register store: 4 channels x 8 registers, registered read data
module qhp_regmem #(
  parameter int NCH = qhp_pkg::NUM_CH,
  parameter int AW = qhp_pkg::ADDR_W,
  parameter int DW = qhp_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [$clog2(NCH)-1:0] rd_ch,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_r [NCH][2**AW];

  // ****************************************
  // storage, every selected channel written at once
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        for (int a = 0; a < 2**AW; a++) begin
          mem_r[c][a] <= qhp_pkg::REG_RESET;
        end
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_en[c]) begin
          mem_r[c][addr] <= wdata;
        end
      end
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= qhp_pkg::REG_RESET;
    end else begin
      rdata <= mem_r[rd_ch][addr];
    end
  end
endmodule : qhp_regmem

// file: sim/qhp_host_model.sv
// ****
// host processor on the parallel bus
// ****
module qhp_host_model (
  input wire logic clk,
  input wire logic style,
  output logic cs_a,
  output logic cs_b,
  output logic cs_c,
  output logic cs_d,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  output logic [7:0] bus_in,
  input wire logic [7:0] dout,
  input wire logic oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hdrv = 1'b0;
  logic [7:0] hdat = 8'h00;
  logic [7:0] last = 8'h00;
  // idle select and strobe pins high, addr low
  initial begin
    {cs_d, cs_c, cs_b, cs_a} = 4'hF;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
  end
  // wire level; a floating bus flips every cycle so no stale byte reads true
  always_comb begin
    if (oe) bus_in = dout;
    else if (hdrv) bus_in = hdat;
    else bus_in = ~last;
  end
  always @(posedge clk) last <= bus_in;
  // one bus cycle; cs holds pins d..a as driven
  task automatic cyc(input logic rd, input logic [3:0] cs, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic seen);
    seen = 1'b0;
    @(negedge clk);
    {cs_d, cs_c, cs_b, cs_a} = cs;
    addr = a;
    hdat = d;
    hdrv = !rd;
    wr_n = rd;
    if (style) rd_n = !rd;
    repeat (6) begin
      @(negedge clk);
      seen = seen | oe;
    end
    q = bus_in;
    if (style) begin
      rd_n = 1'b1;
      wr_n = 1'b1;
    end else begin
      cs_a = 1'b1;
    end
    // byte held past the rise so the load sees it stable
    repeat (4) @(negedge clk);
    {cs_d, cs_c, cs_b, cs_a} = 4'hF;
    hdrv = 1'b0;
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : cyc
endmodule : qhp_host_model

// file: sim/qhp_host_port_tb.sv
// ****
// bench
// ****
module qhp_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic style = 1'b1;
  logic rpin = 1'b0;
  logic strap = 1'b1;
  logic [3:0] rx = 4'hF;
  logic [3:0] ring = 4'hF;
  logic chclk = 1'b0;
  logic cs_a, cs_b, cs_c, cs_d, rd_n, wr_n, oe, seen, chc;
  logic [2:0] addr;
  logic [7:0] bus, dout, q;
  logic [3:0] tx, ring_st, crst, div4;
  int err_total = 0;
  int compares = 0;
  always #25 clk = ~clk;
  qhp_host_port DUT (.clk(clk), .rst_n(rst_n), .bus_style_select(style), .reset_pin(rpin),
    .prescaler_strap(strap), .chip_select_a(cs_a), .chip_select_b(cs_b),
    .chip_select_c(cs_c), .chip_select_d(cs_d), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr(addr), .data_in(bus), .data_out(dout), .data_oe(oe),
    .serial_rx(rx), .ring_indicator(ring), .third_channel_clock_in(chclk),
    .serial_tx(tx), .ring_status(ring_st), .chan_reset(crst), .prescale_div4(div4),
    .chc_clock_level(chc));
  qhp_host_model host (.clk(clk), .style(style), .cs_a(cs_a), .cs_b(cs_b), .cs_c(cs_c),
    .cs_d(cs_d), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .bus_in(bus), .dout(dout), .oe(oe));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask : clks
  task automatic wr(input logic [3:0] cs, input logic [2:0] a, input logic [7:0] d);
    host.cyc(1'b0, cs, a, d, q, seen);
    chk("write_oe", 8'h00, {7'h0, seen});
  endtask : wr
  task automatic rd(input logic [3:0] cs, input logic [2:0] a, input logic [7:0] e,
                    input logic oe_e);
    host.cyc(1'b1, cs, a, 8'h00, q, seen);
    chk("read_oe", {7'h0, oe_e}, {7'h0, seen});
    if (oe_e) chk("read_data", e, q);
  endtask : rd
  // pin reset at the level the bus style asks for; rx toggled to prove it is ignored
  task automatic pin_rst(input logic sv);
    @(negedge clk);
    strap = sv;
    rpin = style;
    rx = 4'h0;
    clks(4);
    chk("chan_reset", 8'h0F, {4'h0, crst});
    chk("tx_in_reset", 8'h0F, {4'h0, tx});
    rpin = !style;
    rx = 4'hF;
    clks(6);
    chk("chan_reset_off", 8'h00, {4'h0, crst});
  endtask : pin_rst
  task automatic t_reset;
    pin_rst(1'b0);
    chk("div4_strap0", 8'h0F, {4'h0, div4});
    strap = 1'b1;
    clks(4);
    chk("div4_held", 8'h0F, {4'h0, div4});
    pin_rst(1'b1);
    chk("div4_strap1", 8'h00, {4'h0, div4});
  endtask : t_reset
  task automatic t_strobe;
    for (int i = 0; i < 4; i++) wr(~(4'h1 << i), 3'h3, 8'hA0 + i[7:0]);
    for (int i = 0; i < 4; i++) rd(~(4'h1 << i), 3'h3, 8'hA0 + i[7:0], 1'b1);
    rd(4'hF, 3'h3, 8'h00, 1'b0);
    wr(4'h0, 3'h6, 8'h5C);
    for (int i = 0; i < 4; i++) rd(~(4'h1 << i), 3'h6, 8'h5C, 1'b1);
    rd(4'hC, 3'h6, 8'h00, 1'b0);
    rd(4'hE, 3'h3, 8'hA0, 1'b1);
  endtask : t_strobe
  // only bit 7 of the modem control register may move the prescaler
  task automatic t_presc;
    wr(4'h7, qhp_pkg::MCR_ADDR, 8'h7F);
    wr(4'hD, qhp_pkg::MCR_ADDR, 8'h01 << qhp_pkg::PRESC_BIT);
    clks(2);
    chk("div4_sw", 8'h02, {4'h0, div4});
    wr(4'hD, qhp_pkg::MCR_ADDR, 8'h00);
    clks(2);
    chk("div4_sw_off", 8'h00, {4'h0, div4});
  endtask : t_presc
  function automatic logic [3:0] rwcs(input int i);
    return {1'b1, i[1], i[0], 1'b0};
  endfunction : rwcs
  task automatic t_rw;
    @(negedge clk);
    style = 1'b0;
    rpin = 1'b1;
    clks(8);
    pin_rst(1'b1);
    for (int i = 0; i < 4; i++) wr(rwcs(i), 3'h2, 8'hC0 + i[7:0]);
    for (int i = 0; i < 4; i++) rd(rwcs(i), 3'h2, 8'hC0 + i[7:0], 1'b1);
    rd(4'hF, 3'h2, 8'h00, 1'b0);
  endtask : t_rw
  task automatic t_misc;
    @(negedge clk);
    ring = 4'h5;
    chclk = 1'b1;
    clks(4);
    chk("ring_status", 8'h05, {4'h0, ring_st});
    chk("tx_idle", 8'h0F, {4'h0, tx});
    chk("chc_level", 8'h01, {7'h0, chc});
  endtask : t_misc
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    clks(6);
    rst_n = 1'b1;
    clks(4);
    t_reset();
    t_strobe();
    t_presc();
    t_misc();
    t_rw();
    test_done();
  end
  // watchdog, several times the expected run
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule : qhp_host_port_tb
